// *** rtl/otb_transceiver.v ***
// Function
// (RULE1) a rising capture clock stores its own port into its register.
// (RULE2) two independent registers, each loaded only by its own clock.
// (RULE3) with enable high no port is driven; registers load or hold.
// (RULE4) enable low: direction low drives port A, high drives port B.
// (RULE5) driving A with the B-to-A select low passes live B to A.
// (RULE6) driving A with the B-to-A select high shows the B register.
// (RULE7) driving B: A-to-B select low gives live A, high the A register.
// (RULE8) register loading never depends on output enable or direction.
// (RULE9) the undriven port may be stored in either register or in both.
// (RULE10) outside agents never drive the port the device drives.
// (RULE11) clocking a driven port's register loads what that port carries.
`timescale 1ns/100ps
`default_nettype none
`include "otb_defines.vh"

module otb_transceiver #(
	parameter BUS_W = `OTB_BUS_W
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             resetn,
	// control pins
	input  wire             output_enable_n,
	input  wire             direction,
	input  wire             a_to_b_source_select,
	input  wire             b_to_a_source_select,
	input  wire             a_side_capture_clock,
	input  wire             b_side_capture_clock,
	// port a pin
	input  wire [BUS_W-1:0] port_a_lines_in,
	output reg  [BUS_W-1:0] port_a_lines_out,
	output wire [BUS_W-1:0] port_a_lines_oe,
	// port b pin
	input  wire [BUS_W-1:0] port_b_lines_in,
	output reg  [BUS_W-1:0] port_b_lines_out,
	output wire [BUS_W-1:0] port_b_lines_oe,
	// stored contents
	output wire [BUS_W-1:0] a_store_value,
	output wire [BUS_W-1:0] b_store_value,
	// capture stream
	output wire             cap_valid,
	input  wire             cap_ready,
	output wire             cap_from_a,
	output wire             cap_from_b,
	output wire [BUS_W-1:0] cap_a_data,
	output wire [BUS_W-1:0] cap_b_data,
	// stream loss status
	output reg              cap_overflow,
	input  wire             cap_overflow_clear
);

	// *******************************************************
	// driving modes
	// *******************************************************
	localparam [1:0] MODE_ISOLATE = 2'b00;
	localparam [1:0] MODE_DRIVE_A = 2'b01;
	localparam [1:0] MODE_DRIVE_B = 2'b10;

	// *******************************************************
	// helpers
	// *******************************************************
	// live or stored data toward the driven port
	function [BUS_W-1:0] otb_pick;
		input             sel;
		input [BUS_W-1:0] live;
		input [BUS_W-1:0] stored;
		begin
			if (sel == `OTB_SEL_STORED) begin
				otb_pick = stored;
			end else begin
				otb_pick = live;
			end
		end
	endfunction

	// *******************************************************
	// pin synchronisers
	// *******************************************************
	// data and clock pass the same number of stages, so a word
	// set up before its clock edge is seen together with it
	wire [BUS_W-1:0]      a_sync;
	wire [BUS_W-1:0]      b_sync;
	wire [`OTB_CTL_W-1:0] ctl_sync;
	wire                  oen_s;
	wire                  dir_s;
	wire                  a2b_sel_s;
	wire                  b2a_sel_s;
	wire                  clk_a_s;
	wire                  clk_b_s;

	otb_sync #(
		.WIDTH    (BUS_W)
	) u_sync_a (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (port_a_lines_in),
		.sync_out (a_sync)
	);

	otb_sync #(
		.WIDTH    (BUS_W)
	) u_sync_b (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (port_b_lines_in),
		.sync_out (b_sync)
	);

	otb_sync #(
		.WIDTH    (`OTB_CTL_W)
	) u_sync_ctl (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in ({~output_enable_n, direction,
			a_to_b_source_select, b_to_a_source_select,
			a_side_capture_clock, b_side_capture_clock}),
		.sync_out (ctl_sync)
	);

	// the enable crosses inverted, so the cleared sync stages
	// read as disabled and no port is driven just after reset
	assign oen_s     = ~ctl_sync[`OTB_CTL_EN]; // RULE3
	assign dir_s     = ctl_sync[`OTB_CTL_DIR];
	assign a2b_sel_s = ctl_sync[`OTB_CTL_A2B_SEL];
	assign b2a_sel_s = ctl_sync[`OTB_CTL_B2A_SEL];
	assign clk_a_s   = ctl_sync[`OTB_CTL_CLK_A];
	assign clk_b_s   = ctl_sync[`OTB_CTL_CLK_B];

	// *******************************************************
	// capture clock edges
	// *******************************************************
	reg  clk_a_prev_q;
	reg  clk_b_prev_q;
	reg  edge_seen_q;
	wire rise_a;
	wire rise_b;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_a_prev_q <= 1'b0;
			clk_b_prev_q <= 1'b0;
			edge_seen_q  <= 1'b0;
		end else begin
			clk_a_prev_q <= clk_a_s;
			clk_b_prev_q <= clk_b_s;
			edge_seen_q  <= 1'b1;
		end
	end

	// the first cycle after reset only primes the history; a clock
	// already high at release still shows as an edge once the cleared sync stages fill
	assign rise_a = edge_seen_q & clk_a_s & ~clk_a_prev_q; // RULE1
	assign rise_b = edge_seen_q & clk_b_s & ~clk_b_prev_q; // RULE1

	// *******************************************************
	// storage registers
	// *******************************************************
	reg [BUS_W-1:0] a_store_q;
	reg [BUS_W-1:0] b_store_q;

	// loading ignores enable and direction; a driven port is
	// sampled from its pin, so the register takes what the
	// wire carries at that edge
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			a_store_q <= `OTB_REG_RST;
		end else if (rise_a) begin // RULE2 RULE8 RULE9
			a_store_q <= a_sync; // RULE11
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			b_store_q <= `OTB_REG_RST;
		end else if (rise_b) begin // RULE2 RULE8 RULE9
			b_store_q <= b_sync; // RULE11
		end
	end

	assign a_store_value = a_store_q;
	assign b_store_value = b_store_q;

	// *******************************************************
	// mode decode
	// *******************************************************
	reg [1:0] mode_d;
	reg [1:0] mode_q;

	always @* begin
		mode_d = MODE_ISOLATE; // RULE3
		if (oen_s == `OTB_OEN_ACTIVE) begin
			if (dir_s == `OTB_DIR_DRIVE_B) begin
				mode_d = MODE_DRIVE_B; // RULE4
			end else begin
				mode_d = MODE_DRIVE_A; // RULE4
			end
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_ISOLATE;
		end else begin
			mode_q <= mode_d;
		end
	end

	// *******************************************************
	// port drivers
	// *******************************************************
	reg [BUS_W-1:0] a_out_d;
	reg [BUS_W-1:0] b_out_d;
	reg             drive_a;
	reg             drive_b;

	always @* begin
		a_out_d = `OTB_BUS_ZERO;
		b_out_d = `OTB_BUS_ZERO;
		drive_a = 1'b0;
		drive_b = 1'b0;
		case (mode_q)
			MODE_ISOLATE: begin
				drive_a = 1'b0; // RULE3
				drive_b = 1'b0; // RULE3
			end
			MODE_DRIVE_A: begin
				drive_a = 1'b1;
				// RULE5 RULE6
				a_out_d = otb_pick(b2a_sel_s, b_sync, b_store_q);
			end
			MODE_DRIVE_B: begin
				drive_b = 1'b1;
				// RULE7
				b_out_d = otb_pick(a2b_sel_s, a_sync, a_store_q);
			end
			default: begin
				drive_a = 1'b0;
				drive_b = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			port_a_lines_out <= `OTB_BUS_ZERO;
			port_b_lines_out <= `OTB_BUS_ZERO;
		end else begin
			port_a_lines_out <= a_out_d;
			port_b_lines_out <= b_out_d;
		end
	end

	// enables follow the registered mode; data lags it by one
	// cycle, a trade for flop-driven pins at 20 MHz
	genvar bit_i;
	generate
		for (bit_i = 0; bit_i < BUS_W; bit_i = bit_i + 1) begin : g_oe
			assign port_a_lines_oe[bit_i] = drive_a; // RULE4
			assign port_b_lines_oe[bit_i] = drive_b; // RULE4
		end
	endgenerate

	// *******************************************************
	// capture stream
	// *******************************************************
	// loads can not be held off at the pins, so the buffer
	// back-pressure shows as a lost word, flagged below
	wire                   buf_in_ready;
	wire                   buf_in_valid;
	wire [`OTB_WORD_W-1:0] buf_in_data;
	wire [`OTB_WORD_W-1:0] buf_out_data;

	assign buf_in_valid = rise_a | rise_b;
	assign buf_in_data  = {rise_a, rise_b, a_sync, b_sync};

	otb_buf2 #(
		.WIDTH     (`OTB_WORD_W)
	) u_cap_buf (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in_data),
		.out_valid (cap_valid),
		.out_ready (cap_ready),
		.out_data  (buf_out_data)
	);

	assign cap_from_a = buf_out_data[`OTB_WORD_CAP_A];
	assign cap_from_b = buf_out_data[`OTB_WORD_CAP_B];
	assign cap_a_data = buf_out_data[`OTB_WORD_A_MSB:`OTB_WORD_A_LSB];
	assign cap_b_data = buf_out_data[`OTB_WORD_B_MSB:`OTB_WORD_B_LSB];

	// *******************************************************
	// overflow flag
	// *******************************************************
	// a new loss in the clearing cycle keeps the flag set
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cap_overflow <= 1'b0;
		end else if (buf_in_valid && !buf_in_ready) begin
			cap_overflow <= 1'b1;
		end else if (cap_overflow_clear) begin
			cap_overflow <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** inc/otb_defines.vh ***
`ifndef OTB_DEFINES_VH
`define OTB_DEFINES_VH

// ***********************************************************
// widths
// ***********************************************************
`define OTB_BUS_W        8
`define OTB_SYNC_STAGES  2
`define OTB_BUF_DEPTH    2
`define OTB_BUF_CNT_W    2
`define OTB_WORD_W       18

// ***********************************************************
// synchronised control word layout
// ***********************************************************
`define OTB_CTL_W        6
`define OTB_CTL_EN       5
`define OTB_CTL_DIR      4
`define OTB_CTL_A2B_SEL  3
`define OTB_CTL_B2A_SEL  2
`define OTB_CTL_CLK_A    1
`define OTB_CTL_CLK_B    0

// ***********************************************************
// capture word layout {captured_a, captured_b, a_data, b_data}
// ***********************************************************
`define OTB_WORD_CAP_A   17
`define OTB_WORD_CAP_B   16
`define OTB_WORD_A_MSB   15
`define OTB_WORD_A_LSB   8
`define OTB_WORD_B_MSB   7
`define OTB_WORD_B_LSB   0

// ***********************************************************
// reset values and encodings
// ***********************************************************
`define OTB_REG_RST      8'h00
`define OTB_BUS_ZERO     8'h00
`define OTB_BUS_ONES     8'hff
`define OTB_DIR_DRIVE_A  1'b0
`define OTB_DIR_DRIVE_B  1'b1
`define OTB_SEL_LIVE     1'b0
`define OTB_SEL_STORED   1'b1
`define OTB_OEN_ACTIVE   1'b0

`endif

// *** rtl/otb_sync.v ***
`timescale 1ns/100ps
`default_nettype none
`include "otb_defines.vh"

module otb_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             resetn,
	// asynchronous level in, synchronised level out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	// first stage is read only by the second
	reg [WIDTH-1:0] meta_q;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
`default_nettype wire

// *** rtl/otb_buf2.v ***
`timescale 1ns/100ps
`default_nettype none
`include "otb_defines.vh"

module otb_buf2 #(
	parameter WIDTH = `OTB_WORD_W
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             resetn,
	// filling side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// draining side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0]            mem_q [0:`OTB_BUF_DEPTH-1];
	reg                        wr_ptr_q;
	reg                        rd_ptr_q;
	reg [`OTB_BUF_CNT_W-1:0]   count_q;
	wire                       push;
	wire                       pop;

	assign in_ready  = (count_q != `OTB_BUF_DEPTH);
	assign out_valid = (count_q != {`OTB_BUF_CNT_W{1'b0}});
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= {`OTB_BUF_CNT_W{1'b0}};
			mem_q[0] <= {WIDTH{1'b0}};
			mem_q[1] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data;
				wr_ptr_q        <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			if (push && !pop) begin
				count_q <= count_q + 2'd1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'd1;
			end
		end
	end

endmodule
`default_nettype wire

// *** tb/otb_transceiver_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// drive, storage and mux timing at the pins
// ************************************************************
module otb_transceiver_chk (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// control pins
	input wire logic       output_enable_n,
	input wire logic       direction,
	input wire logic       a_to_b_source_select,
	input wire logic       b_to_a_source_select,
	input wire logic       a_side_capture_clock,
	input wire logic       b_side_capture_clock,
	// port pins
	input wire logic [7:0] port_a_lines_in,
	input wire logic [7:0] port_a_lines_out,
	input wire logic [7:0] port_a_lines_oe,
	input wire logic [7:0] port_b_lines_in,
	input wire logic [7:0] port_b_lines_out,
	input wire logic [7:0] port_b_lines_oe,
	// stored contents
	input wire logic [7:0] a_store_value,
	input wire logic [7:0] b_store_value
);
	// the pin synchronisers still carry reset values for a few edges
	logic [2:0] age_q;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			age_q <= 3'h0;
		else if (age_q < 3'h5)
			age_q <= age_q + 3'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn || age_q < 3'h5);
	chk_drive_a: assert property (
		port_a_lines_oe == {8{$past(!output_enable_n && !direction, 3)}})
		else $error("port a enable wrong");
	chk_drive_b: assert property (
		port_b_lines_oe == {8{$past(!output_enable_n && direction, 3)}})
		else $error("port b enable wrong");
	chk_load_a: assert property (
		$rose(a_side_capture_clock) |->
		##3 a_store_value == $past(port_a_lines_in, 3))
		else $error("a store load wrong");
	chk_load_b: assert property (
		$rose(b_side_capture_clock) |->
		##3 b_store_value == $past(port_b_lines_in, 3))
		else $error("b store load wrong");
	chk_hold_a: assert property (
		$changed(a_store_value) |-> $past(a_side_capture_clock, 3)
		&& !$past(a_side_capture_clock, 4))
		else $error("a store changed without its clock");
	chk_hold_b: assert property (
		$changed(b_store_value) |-> $past(b_side_capture_clock, 3)
		&& !$past(b_side_capture_clock, 4))
		else $error("b store changed without its clock");
	chk_live_a: assert property (
		port_a_lines_oe[0] && $past(port_a_lines_oe[0])
		&& !$past(b_to_a_source_select, 3)
		|-> port_a_lines_out == $past(port_b_lines_in, 3))
		else $error("live b data not on port a");
	chk_stored_a: assert property (
		port_a_lines_oe[0] && $past(port_a_lines_oe[0])
		&& $past(b_to_a_source_select, 3)
		|-> port_a_lines_out == $past(b_store_value))
		else $error("b store not on port a");
	chk_mux_b: assert property (
		port_b_lines_oe[0] && $past(port_b_lines_oe[0]) |->
		port_b_lines_out == ($past(a_to_b_source_select, 3)
		? $past(a_store_value) : $past(port_a_lines_in, 3)))
		else $error("port b source wrong");
endmodule
bind otb_transceiver otb_transceiver_chk u_chk (
	.sys_clk              (sys_clk),
	.resetn               (resetn),
	.output_enable_n      (output_enable_n),
	.direction            (direction),
	.a_to_b_source_select (a_to_b_source_select),
	.b_to_a_source_select (b_to_a_source_select),
	.a_side_capture_clock (a_side_capture_clock),
	.b_side_capture_clock (b_side_capture_clock),
	.port_a_lines_in      (port_a_lines_in),
	.port_a_lines_out     (port_a_lines_out),
	.port_a_lines_oe      (port_a_lines_oe),
	.port_b_lines_in      (port_b_lines_in),
	.port_b_lines_out     (port_b_lines_out),
	.port_b_lines_oe      (port_b_lines_oe),
	.a_store_value        (a_store_value),
	.b_store_value        (b_store_value)
);
`default_nettype wire

// *** tb/otb_bus_agent.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// bus agents on ports a and b, resolving each wire
// ************************************************************
module otb_bus_agent (
	input  wire logic       sys_clk,
	input  wire logic       drv_a,
	input  wire logic       drv_b,
	input  wire logic [7:0] val_a,
	input  wire logic [7:0] val_b,
	input  wire logic [7:0] oe_a,
	input  wire logic [7:0] oe_b,
	input  wire logic [7:0] out_a,
	input  wire logic [7:0] out_b,
	output var  logic [7:0] wire_a,
	output var  logic [7:0] wire_b
);
	logic [7:0] last_a = 8'h00;
	logic [7:0] last_b = 8'h00;
	// a floating line toggles so a stale level never passes for data
	always_comb begin
		wire_a = ~last_a;
		wire_b = ~last_b;
		if (oe_a[0])
			wire_a = out_a;
		else if (drv_a)
			wire_a = val_a;
		if (oe_b[0])
			wire_b = out_b;
		else if (drv_b)
			wire_b = val_b;
	end
	always @(posedge sys_clk) begin
		last_a <= wire_a;
		last_b <= wire_b;
	end
endmodule
`default_nettype wire

// *** tb/test_octal_registered_bus_transceiver.sv ***
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// mode sweep, captures and capture stream
// ************************************************************
module test_octal_registered_bus_transceiver;
	logic       sys_clk, resetn = 1'b0;
	logic       output_enable_n = 1'b1, direction = 1'b0;
	logic       a_to_b_source_select = 1'b0, b_to_a_source_select = 1'b0;
	logic       a_side_capture_clock = 1'b0, b_side_capture_clock = 1'b0;
	logic       cap_ready = 1'b0, cap_overflow_clear = 1'b0;
	logic       cap_valid, cap_from_a, cap_from_b, cap_overflow;
	logic [7:0] port_a_lines_in, port_a_lines_out, port_a_lines_oe;
	logic [7:0] port_b_lines_in, port_b_lines_out, port_b_lines_oe;
	logic [7:0] a_store_value, b_store_value, cap_a_data, cap_b_data;
	logic [7:0] va = 8'h00, vb = 8'h00;
	int         fails = 0, n_tests = 0, ma = 0, mb = 0, q[$];
	otb_transceiver DUT (
		.sys_clk              (sys_clk),
		.resetn               (resetn),
		.output_enable_n      (output_enable_n),
		.direction            (direction),
		.a_to_b_source_select (a_to_b_source_select),
		.b_to_a_source_select (b_to_a_source_select),
		.a_side_capture_clock (a_side_capture_clock),
		.b_side_capture_clock (b_side_capture_clock),
		.port_a_lines_in      (port_a_lines_in),
		.port_a_lines_out     (port_a_lines_out),
		.port_a_lines_oe      (port_a_lines_oe),
		.port_b_lines_in      (port_b_lines_in),
		.port_b_lines_out     (port_b_lines_out),
		.port_b_lines_oe      (port_b_lines_oe),
		.a_store_value        (a_store_value),
		.b_store_value        (b_store_value),
		.cap_valid            (cap_valid),
		.cap_ready            (cap_ready),
		.cap_from_a           (cap_from_a),
		.cap_from_b           (cap_from_b),
		.cap_a_data           (cap_a_data),
		.cap_b_data           (cap_b_data),
		.cap_overflow         (cap_overflow),
		.cap_overflow_clear   (cap_overflow_clear)
	);
	otb_bus_agent u_agent (
		.sys_clk (sys_clk),
		.drv_a   (output_enable_n | direction),
		.drv_b   (output_enable_n | ~direction),
		.val_a   (va),
		.val_b   (vb),
		.oe_a    (port_a_lines_oe),
		.oe_b    (port_b_lines_oe),
		.out_a   (port_a_lines_out),
		.out_b   (port_b_lines_out),
		.wire_a  (port_a_lines_in),
		.wire_b  (port_b_lines_in)
	);
	function automatic int exp_a();
		if (output_enable_n || direction)
			return va;
		return b_to_a_source_select ? mb : vb;
	endfunction
	function automatic int exp_b();
		if (output_enable_n || !direction)
			return vb;
		return a_to_b_source_select ? ma : va;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input string nm, input int e, input logic [17:0] g);
		n_tests++;
		if (g !== 18'(e)) begin
			fails++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic capture(input bit ca, input bit cb);
		int wa, wb;
		wa = exp_a();
		wb = exp_b();
		a_side_capture_clock = ca;
		b_side_capture_clock = cb;
		if (ca)
			ma = wa;
		if (cb)
			mb = wb;
		q.push_back({ca, cb, wa[7:0], wb[7:0]});
		step(3);
		a_side_capture_clock = 1'b0;
		b_side_capture_clock = 1'b0;
		step(3);
	endtask
	task automatic drain();
		int t;
		cap_ready = 1'b1;
		while (q.size() > 0) begin
			t = 0;
			while (cap_valid !== 1'b1 && t < 20) begin
				step(1);
				t++;
			end
			check("cap_word", q.pop_front(),
				{cap_from_a, cap_from_b, cap_a_data, cap_b_data});
			step(1);
		end
		cap_ready = 1'b0;
		step(1);
		check("cap_empty", 0, cap_valid);
	endtask
	task automatic conclude();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever
			#25 sys_clk = ~sys_clk;
	end
	initial begin
		#200_000;
		fails++;
		conclude();
	end
	initial begin
		int k;
		bit da, db;
		void'($urandom(42));
		step(5);
		resetn = 1'b1;
		// enable pin still high: nothing may drive in the first edges
		step(2);
		check("a_oe", 0, port_a_lines_oe);
		check("b_oe", 0, port_b_lines_oe);
		for (int i = 0; i < 16; i++) begin
			{output_enable_n, direction, a_to_b_source_select,
				b_to_a_source_select} = i[3:0];
			da = !output_enable_n && !direction;
			db = !output_enable_n && direction;
			va = $urandom;
			vb = $urandom;
			step(6);
			k = $urandom_range(3, 1);
			capture(k[0], k[1]);
			step(3);
			check("a_oe", da ? 8'hff : 8'h00, port_a_lines_oe);
			check("b_oe", db ? 8'hff : 8'h00, port_b_lines_oe);
			check("a_out", da ? exp_a() : 0, port_a_lines_out);
			check("b_out", db ? exp_b() : 0, port_b_lines_out);
			check("a_store", ma, a_store_value);
			check("b_store", mb, b_store_value);
			drain();
		end
		// a third word with the buffer full is lost but the store still loads
		for (int j = 0; j < 3; j++) begin
			va = $urandom;
			step(2);
			capture(1'b1, 1'b0);
		end
		void'(q.pop_back());
		check("a_store", ma, a_store_value);
		check("overflow", 1, cap_overflow);
		drain();
		cap_overflow_clear = 1'b1;
		step(1);
		cap_overflow_clear = 1'b0;
		step(1);
		check("overflow", 0, cap_overflow);
		conclude();
	end
endmodule
`default_nettype wire
